// file: hdl/asc_pkg.sv
// package: timing and layout constants for the static memory controller
package asc_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned ADDR_W         = 13;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned CYCLE_MIN_NS   = 70;
  localparam int unsigned WR_PULSE_NS    = 50;
  localparam int unsigned CS_TO_END_NS   = 65;
  localparam int unsigned ACCESS_NS      = 70;
  localparam int unsigned RECOVER_NS     = 70;
  localparam int unsigned CYCLE_CYC      = (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_PULSE_CYC   = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CS_TO_END_CYC  = (CS_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYC    = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 4;
  typedef enum logic [2:0] {
    ASC_IDLE, ASC_RD, ASC_WR, ASC_WR_END, ASC_RET, ASC_RECOVER
  } asc_state_t;
endpackage

// file: hdl/asc_ctrl.sv
// static memory controller driving an 8k x 8 asynchronous memory
// How it works
// [R1] memory holds 8192 words of 8 bits
// [R2] selects asserted together to activate memory
// [R3] address and controls presented together
// [R4] write strobe and output enable set mode
// [R5] new address starts a new cycle
// [R6] read data sampled after output enable low
// [R7] data sampled only after full access time
// [R8] read ended by raising output enable, selects
// [R9] never trust undriven data lines
// [R10] high select low deselects memory
// [R11] memory releases bus 25 ns after deselect
// [R12] memory releases bus 30 ns after strobe
// [R13] memory releases bus 25 ns after enable
// [R14] every cycle at least 70 ns
// [R15] strobe low 50 ns, selects 65 ns
// [R16] write bounded by strobe and select overlap
// [R17] deselect before and during data retention
// [R18] wait one read cycle after retention
// [R19] address lines map binary, line 0 lsb
// [R20] memory contents undefined until written
`timescale 1ns/1ns
module asc_ctrl #(
  parameter int unsigned ADDR_W = asc_pkg::ADDR_W,
  parameter int unsigned DATA_W = asc_pkg::DATA_W
) (
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   req_ready_o,
  output logic                   rd_valid_o,
  output logic [DATA_W-1:0]      rd_data_o,
  input  wire logic              retain_i,
  output logic                   retain_ok_o,
  output logic [ADDR_W-1:0]      word_address_lines_o,
  output logic                   chip_select_low_o,
  output logic                   chip_select_high_o,
  output logic                   out_enable_low_o,
  output logic                   write_strobe_low_o,
  input  wire logic [DATA_W-1:0] bidir_data_lines_i,
  output logic [DATA_W-1:0]      bidir_data_lines_o,
  output logic                   bidir_data_lines_oe_o
);

  typedef logic [asc_pkg::CNT_W-1:0] asc_cnt_t;

  // counter loads are one less than the cycles waited
  localparam int unsigned WR_LOW_CYC = (asc_pkg::WR_PULSE_CYC > asc_pkg::CS_TO_END_CYC) ?
                                       asc_pkg::WR_PULSE_CYC : asc_pkg::CS_TO_END_CYC;
  localparam asc_cnt_t    RD_LD      = asc_cnt_t'(asc_pkg::ACCESS_CYC - 1);
  localparam asc_cnt_t    WR_LD      = asc_cnt_t'(WR_LOW_CYC - 1);
  localparam asc_cnt_t    REC_LD     = asc_cnt_t'(asc_pkg::RECOVER_CYC - 1);
  localparam asc_cnt_t    GAP_LD     = asc_cnt_t'(asc_pkg::CYCLE_CYC - 1);
  localparam asc_cnt_t    CNT_ONE    = asc_cnt_t'(1);

  asc_pkg::asc_state_t state_r, state_nxt;
  asc_cnt_t            cnt_r, cnt_nxt;
  asc_cnt_t            gap_r, gap_nxt;
  logic [ADDR_W-1:0]   addr_r, addr_nxt;
  logic [DATA_W-1:0]   wdat_r, wdat_nxt;
  logic [DATA_W-1:0]   rdat_r, rdat_nxt;
  logic                rdv_r, rdv_nxt;
  logic                csl_r, csl_nxt;
  logic                csh_r, csh_nxt;
  logic                oel_r, oel_nxt;
  logic                wel_r, wel_nxt;
  logic                drv_r, drv_nxt;
  logic                acc_take;
  logic                rd_end;
  logic                wr_end;
  logic                ret_enter;
  logic                ret_exit;

  // events shared by the groups below
  assign req_ready_o = (state_r == asc_pkg::ASC_IDLE) && !retain_i && (gap_r == '0); // [R14]
  assign acc_take    = req_ready_o && req_valid_i;
  assign ret_enter   = (state_r == asc_pkg::ASC_IDLE) && retain_i; // [R17]
  assign rd_end      = (state_r == asc_pkg::ASC_RD) && (cnt_r == '0); // [R7]
  assign wr_end      = (state_r == asc_pkg::ASC_WR) && (cnt_r == '0); // [R15]
  assign ret_exit    = (state_r == asc_pkg::ASC_RET) && !retain_i; // [R18]

  // sequencer: access phase and its wait counter
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - CNT_ONE : '0;
    case (state_r)
      asc_pkg::ASC_IDLE: begin
        if (ret_enter) begin
          state_nxt = asc_pkg::ASC_RET; // [R17]
        end else if (acc_take) begin
          if (req_write_i) begin
            cnt_nxt   = WR_LD; // [R15]
            state_nxt = asc_pkg::ASC_WR;
          end else begin
            cnt_nxt   = RD_LD; // [R7] [R14]
            state_nxt = asc_pkg::ASC_RD;
          end
        end
      end
      asc_pkg::ASC_RD: begin
        if (rd_end) begin
          state_nxt = asc_pkg::ASC_IDLE; // [R8]
        end
      end
      asc_pkg::ASC_WR: begin
        if (wr_end) begin
          state_nxt = asc_pkg::ASC_WR_END; // [R16]
        end
      end
      asc_pkg::ASC_WR_END: begin
        state_nxt = asc_pkg::ASC_IDLE; // [R14]
      end
      asc_pkg::ASC_RET: begin
        if (ret_exit) begin
          cnt_nxt   = REC_LD; // [R18]
          state_nxt = asc_pkg::ASC_RECOVER;
        end
      end
      asc_pkg::ASC_RECOVER: begin
        if (cnt_r == '0) begin
          state_nxt = asc_pkg::ASC_IDLE; // [R18]
        end
      end
      default: begin
        state_nxt = asc_pkg::ASC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r <= asc_pkg::ASC_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // pins: address, selects, strobes and write data drive
  always_comb begin
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    csl_nxt  = csl_r;
    csh_nxt  = csh_r;
    oel_nxt  = oel_r;
    wel_nxt  = wel_r;
    drv_nxt  = drv_r;
    if (ret_enter) begin
      csl_nxt = 1'b1; // [R17]
      csh_nxt = 1'b0; // [R10] [R17]
      oel_nxt = 1'b1;
      wel_nxt = 1'b1;
      drv_nxt = 1'b0;
    end else if (acc_take) begin
      addr_nxt = req_addr_i; // [R19] [R5]
      wdat_nxt = req_wdata_i;
      csl_nxt  = 1'b0; // [R2] [R3]
      csh_nxt  = 1'b1; // [R2]
      wel_nxt  = !req_write_i; // [R4] [R16]
      oel_nxt  = req_write_i; // [R4] [R6]
      drv_nxt  = req_write_i; // [R9] [R12]
    end else if (rd_end) begin
      oel_nxt = 1'b1; // [R8] [R13]
      csl_nxt = 1'b1;
      csh_nxt = 1'b0; // [R10] [R11]
    end else if (wr_end) begin
      wel_nxt = 1'b1; // [R15] [R16]
    end else if (state_r == asc_pkg::ASC_WR_END) begin
      // data held one cycle past the strobe for hold time
      drv_nxt = 1'b0;
      csl_nxt = 1'b1;
      csh_nxt = 1'b0; // [R14]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      addr_r <= '0;
      wdat_r <= '0;
      csl_r  <= 1'b1;
      csh_r  <= 1'b0;
      oel_r  <= 1'b1;
      wel_r  <= 1'b1;
      drv_r  <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      csl_r  <= csl_nxt;
      csh_r  <= csh_nxt;
      oel_r  <= oel_nxt;
      wel_r  <= wel_nxt;
      drv_r  <= drv_nxt;
    end
  end

  // read capture: sample the bus once the access time has passed
  always_comb begin
    rdat_nxt = rdat_r;
    rdv_nxt  = 1'b0;
    if (rd_end) begin
      rdat_nxt = bidir_data_lines_i; // [R7] [R9]
      rdv_nxt  = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdat_r <= '0;
      rdv_r  <= 1'b0;
    end else begin
      rdat_r <= rdat_nxt;
      rdv_r  <= rdv_nxt;
    end
  end

  // cycle guard: no new address before a full cycle time
  always_comb begin
    gap_nxt = (gap_r != '0) ? gap_r - CNT_ONE : '0;
    if (acc_take) begin
      gap_nxt = GAP_LD; // [R14]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_nxt;
    end
  end

  assign rd_valid_o            = rdv_r;
  assign rd_data_o             = rdat_r;
  assign retain_ok_o           = (state_r == asc_pkg::ASC_RET);
  assign word_address_lines_o  = addr_r;
  assign chip_select_low_o     = csl_r;
  assign chip_select_high_o    = csh_r;
  assign out_enable_low_o      = oel_r;
  assign write_strobe_low_o    = wel_r;
  assign bidir_data_lines_o    = wdat_r;
  assign bidir_data_lines_oe_o = drv_r;
endmodule

// file: dv/asc_ctrl_assertions.sv
// checker: controller pin protocol properties
`timescale 1ns/1ns
module asc_ctrl_chk (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        retain_ok_o,
  input wire logic [12:0] word_address_lines_o,
  input wire logic        chip_select_low_o,
  input wire logic        chip_select_high_o,
  input wire logic        out_enable_low_o,
  input wire logic        write_strobe_low_o,
  input wire logic        bidir_data_lines_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  property p_cyc;
    $fell(chip_select_low_o) |=> !chip_select_low_o && $stable(word_address_lines_o);
  endproperty
  a_cyc: assert property (p_cyc) else $error("cycle too short");
  property p_wp;
    $fell(write_strobe_low_o) |=> !write_strobe_low_o;
  endproperty
  a_wp: assert property (p_wp) else $error("strobe too short");
  property p_cse;
    $rose(write_strobe_low_o) |->
      !$past(chip_select_low_o, 2) && $past(chip_select_high_o, 2);
  endproperty
  a_cse: assert property (p_cse) else $error("select too short before write end");
  property p_wsel;
    !write_strobe_low_o |-> !chip_select_low_o && chip_select_high_o && bidir_data_lines_oe_o;
  endproperty
  a_wsel: assert property (p_wsel) else $error("write outside select");
  property p_rd;
    !out_enable_low_o |-> !bidir_data_lines_oe_o;
  endproperty
  a_rd: assert property (p_rd) else $error("bus fight on read");
  property p_ret;
    retain_ok_o |-> chip_select_low_o && !chip_select_high_o;
  endproperty
  a_ret: assert property (p_ret) else $error("selected in retention");
  property p_rec;
    $fell(retain_ok_o) |-> chip_select_low_o [*3];
  endproperty
  a_rec: assert property (p_rec) else $error("no recovery wait");
endmodule
bind asc_ctrl asc_ctrl_chk asc_ctrl_chk_i (.mclk_i, .sys_rst_i, .retain_ok_o,
  .word_address_lines_o, .chip_select_low_o, .chip_select_high_o, .out_enable_low_o,
  .write_strobe_low_o, .bidir_data_lines_oe_o);

// file: dv/asc_sram_model.sv
// model: 8k x 8 static memory on the controller pins
`timescale 1ns/1ns
module asc_sram_model #(parameter int ACC_NS = 70) (
  input wire logic [12:0] addr_i,
  input wire logic        csl_i,
  input wire logic        csh_i,
  input wire logic        oen_i,
  input wire logic        wen_i,
  input wire logic [7:0]  dq_i,
  output logic     [7:0]  dq_o,
  output logic            dq_oe_o
);
  logic [7:0] mem [8192];
  wire act = !csl_i && csh_i;
  always @* if (act && !wen_i) mem[addr_i] = dq_i;
  assign #(ACC_NS) dq_o = mem[addr_i];
  assign #(5, 25) dq_oe_o = act && wen_i && !oen_i;
endmodule

// file: dv/tb_asc_ctrl.sv
// testbench: controller against the memory model
`timescale 1ns/1ns
module tb_asc_ctrl;
  logic        mclk_i = 0, sys_rst_i = 1, req_valid_i = 0, req_write_i = 0, retain_i = 0;
  logic [12:0] req_addr_i = 13'h0000;
  logic [7:0]  req_wdata_i = 8'h00;
  wire         req_ready_o, rd_valid_o, retain_ok_o, csl, csh, oen, wen, c_oe, m_oe;
  wire  [7:0]  rd_data_o, c_o, m_o;
  wire  [12:0] adr;
  // released bus wanders every cycle
  wire  [7:0]  dq = c_oe ? c_o : m_oe ? m_o : {8{mclk_i}} ^ 8'h5A;
  int          fail_count = 0, n_tests = 0;
  asc_ctrl asc_ctrl_i (.mclk_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_addr_i,
    .req_wdata_i, .req_ready_o, .rd_valid_o, .rd_data_o, .retain_i, .retain_ok_o,
    .word_address_lines_o(adr), .chip_select_low_o(csl), .chip_select_high_o(csh),
    .out_enable_low_o(oen), .write_strobe_low_o(wen), .bidir_data_lines_i(dq),
    .bidir_data_lines_o(c_o), .bidir_data_lines_oe_o(c_oe));
  asc_sram_model asc_sram_model_i (.addr_i(adr), .csl_i(csl), .csh_i(csh), .oen_i(oen),
    .wen_i(wen), .dq_i(dq), .dq_o(m_o), .dq_oe_o(m_oe));
  initial forever #25 mclk_i = ~mclk_i;
  task chk(input string s, input logic [12:0] e, input logic [12:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task acc(input logic w, input logic [12:0] a, input logic [7:0] d);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    do @(posedge mclk_i); while (req_ready_o !== 1'b1);
  endtask
  task rd(input logic [12:0] a, input logic [7:0] e);
    int k;
    acc(1'b0, a, 8'h00);
    req_valid_i <= 1'b0;
    k = 0;
    do begin
      @(negedge mclk_i);
      k++;
    end while (rd_valid_o !== 1'b1 && k < 9);
    chk("rd_valid", 13'h0001, 13'(rd_valid_o));
    chk("rd_lat", 13'(asc_pkg::ACCESS_CYC + 1), 13'(k));
    chk("rd_data", 13'(e), 13'(rd_data_o));
    @(posedge mclk_i);
  endtask
  task t_wr_rd;
    acc(1'b1, 13'h0000, 8'hA5);
    acc(1'b1, 13'h1FFF, 8'h3C);
    acc(1'b1, 13'h0001, 8'h5A);
    rd(13'h1FFF, 8'h3C);
    rd(13'h0000, 8'hA5);
    rd(13'h0001, 8'h5A);
    acc(1'b1, 13'h0000, 8'hC3);
    rd(13'h0000, 8'hC3);
  endtask
  task t_ret;
    retain_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("retain_ok", 13'h0001, 13'(retain_ok_o));
    chk("sel_high", 13'h0000, 13'(csh));
    chk("ready", 13'h0000, 13'(req_ready_o));
    retain_i <= 1'b0;
    rd(13'h1FFF, 8'h3C);
  endtask
  task test_done;
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    t_wr_rd;
    t_ret;
    test_done;
  end
  initial begin
    #150000;
    fail_count++;
    test_done;
  end
endmodule
